// ===== design/motor_ctrl_pkg.sv
// motor controller status and control-a constants, shared by design and bench
// assumes a 32-bit apb slave with each register in the low bits of a word, 8 bits wide except option (12) and ratio (4)
// Summary of operation
// - reset clears event status and control a to zero
// - status bit 7 sets when pwm compare preloads reach active copies
// - autoswitched or speed-sensor mode: bits 6 and 5 are ratio pending flags
// - switched mode, bit 6 set: step ratio up, timers shift right, at commutation
// - switched mode, bit 5 set: step ratio down, timers shift left, at commutation
// - bit 4 flags current limitation, bit 3 flags emergency stop
// - bit 2 zero crossing, bit 1 end of demagnetisation, bit 0 commutation
// - writing all ones transfers preloads and sets update flag while clocks run
// - autoswitched mode: hardware sets flags, software writes zero to clear
// - control bit 7 zero puts all six outputs in reset state
// - reset state per output is hi-z, high or low from option bits
// - outputs off, sensorless, pwm sampling: zero sampling per select bit
// - control bit 6 zero stops clocks, event detection and preload transfers
// - register writes still work while peripheral clocks are stopped
// - direct access, clocks off: outputs carry static phase-state levels only
// - clocks off, outputs on: pwm outputs hold 1 voltage, 0 current mode
// - pwm counter held reset while clock off; enabling transfers preloads
// - control bit 5 selects sensorless when zero, position sensor when one
// - flag requests interrupt only with mask set and global mask clear

package motor_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL_A = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_OPTION = 8'h0c;
  localparam logic [7:0] OFS_RATIO  = 8'h10;
  // status bit positions
  localparam int BIT_PWM_UPDATE = 7;
  localparam int BIT_RATIO_INC  = 6;
  localparam int BIT_RATIO_DEC  = 5;
  localparam int BIT_CUR_LIMIT  = 4;
  localparam int BIT_EMERGENCY  = 3;
  localparam int BIT_ZERO_CROSS = 2;
  localparam int BIT_DEMAG_END  = 1;
  localparam int BIT_COMMUT     = 0;
  // control a bit positions
  localparam int BIT_OUT_ENABLE = 7;
  localparam int BIT_CLK_ENABLE = 6;
  localparam int BIT_POS_SENSOR = 5;
  // reset values
  localparam logic [7:0]  RST_STATUS = 8'h00;
  localparam logic [7:0]  RST_CTRL_A = 8'h00;
  localparam logic [7:0]  RST_MASK   = 8'h00;
  localparam logic [11:0] RST_OPTION = 12'h000;
  localparam logic [3:0]  RST_RATIO  = 4'h0;
  // special status write value and ratio limits
  localparam logic [7:0] STATUS_FORCE_UPD = 8'hff;
  localparam logic [3:0] RATIO_MAX        = 4'hf;
  localparam logic [3:0] RATIO_MIN        = 4'h0;
  // per-output reset state codes
  localparam logic [1:0] OPT_HIZ  = 2'h0;
  localparam logic [1:0] OPT_HIGH = 2'h1;
  localparam logic [1:0] OPT_LOW  = 2'h2;
  // commutation phase codes
  localparam logic [1:0] SEG_C_TO_D = 2'h0;
  localparam logic [1:0] SEG_D_TO_Z = 2'h1;
  localparam logic [1:0] SEG_Z_TO_C = 2'h2;
endpackage : motor_ctrl_pkg

// ===== design/motor_ctrl_regs.sv
// motor controller event status, control a, mask, option and ratio registers
// assumes an apb master on i_sys_clk and event pulses from same-clock logic
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module motor_ctrl_regs #(
  parameter int NUM_OUT = 6
) (
  // clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_arst_n,
  // apb slave
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  output logic [31:0]             o_prdata,
  // hardware events, one-cycle pulses
  input  wire logic               i_pwm_update_done,
  input  wire logic               i_evt_ratio_inc,
  input  wire logic               i_evt_ratio_dec,
  input  wire logic               i_evt_cur_limit,
  input  wire logic               i_evt_emergency,
  input  wire logic               i_evt_zero_cross,
  input  wire logic               i_evt_demag_end,
  input  wire logic               i_evt_commutation,
  // mode inputs from neighbouring registers
  input  wire logic [1:0]         i_sensor_type_select,
  input  wire logic               i_autoswitch_select,
  input  wire logic               i_voltage_current_select,
  input  wire logic               i_direct_access,
  input  wire logic               i_sampling_clock_select,
  input  wire logic               i_zero_sampling_select,
  input  wire logic [2:0]         i_output_mode_bits,
  input  wire logic [1:0]         i_phase_segment,
  input  wire logic               i_global_int_mask,
  // phase sources
  input  wire logic [NUM_OUT-1:0] i_pwm_phase,
  input  wire logic [NUM_OUT-1:0] i_pwm_applied,
  input  wire logic [NUM_OUT-1:0] i_phase_state_register,
  // peripheral control
  output logic                    o_periph_clk_run,
  output logic                    o_pwm_counter_reset,
  output logic                    o_preload_transfer,
  output logic                    o_timer_shift_right,
  output logic                    o_timer_shift_left,
  output logic [3:0]              o_step_ratio_prescaler,
  output logic                    o_zero_sampling_run,
  output logic                    o_demag_sampling_run,
  output logic                    o_pwm_on_low,
  output logic                    o_position_sensor_select,
  // motor outputs
  output logic [NUM_OUT-1:0]      o_motor_phase_outputs,
  output logic [NUM_OUT-1:0]      o_motor_phase_oe,
  // interrupt requests per flag
  output logic [7:0]              o_irq_req
);

  // whole block state
  typedef struct packed {
    logic [7:0]           status;
    logic [7:0]           ctrl;
    logic [7:0]           mask;
    logic [2*NUM_OUT-1:0] option;
    logic [3:0]           ratio;
    logic                 cke_d;
    logic                 upd;
    logic                 shr;
    logic                 shl;
    logic [NUM_OUT-1:0]   mco;
    logic [NUM_OUT-1:0]   mco_oe;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  logic       wr_en;
  logic       flag_mode;
  logic       cke;
  logic       motor_output_enable;
  logic       upd_req;
  logic [7:0] wbyte;
  logic [7:0] hw_set;

  // address decode used by the write enable and the error response
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == motor_ctrl_pkg::OFS_STATUS) || (a == motor_ctrl_pkg::OFS_CTRL_A) ||
                  (a == motor_ctrl_pkg::OFS_MASK) || (a == motor_ctrl_pkg::OFS_OPTION) ||
                  (a == motor_ctrl_pkg::OFS_RATIO);
  endfunction : addr_mapped

  // common terms
  assign wr_en     = i_psel && i_penable && i_pwrite && addr_mapped(i_paddr);
  assign wbyte     = i_pwdata[7:0];
  assign cke       = s_r.ctrl[motor_ctrl_pkg::BIT_CLK_ENABLE];
  assign motor_output_enable       = s_r.ctrl[motor_ctrl_pkg::BIT_OUT_ENABLE];
  assign flag_mode = i_autoswitch_select || (i_sensor_type_select != 2'h0);

  // next-state logic
  always_comb begin
    s_nxt   = s_r;
    s_nxt.upd = 1'b0;
    s_nxt.shr = 1'b0;
    s_nxt.shl = 1'b0;
    upd_req = cke && !s_r.cke_d;
    s_nxt.cke_d = cke;
    // register writes work with clocks stopped
    if (wr_en) begin
      case (i_paddr)
        motor_ctrl_pkg::OFS_STATUS: begin
          s_nxt.status = s_r.status & wbyte;
          if (!flag_mode) begin
            s_nxt.status[6:5] = wbyte[6:5];
          end
          if (wbyte == motor_ctrl_pkg::STATUS_FORCE_UPD) begin
            upd_req = 1'b1;
          end
        end
        motor_ctrl_pkg::OFS_CTRL_A: s_nxt.ctrl   = wbyte;
        motor_ctrl_pkg::OFS_MASK:   s_nxt.mask   = wbyte;
        motor_ctrl_pkg::OFS_OPTION: s_nxt.option = i_pwdata[2*NUM_OUT-1:0];
        motor_ctrl_pkg::OFS_RATIO:  s_nxt.ratio  = i_pwdata[3:0];
        default: ;
      endcase
    end
    // preload transfer only with clocks running
    s_nxt.upd = upd_req && cke;
    // hardware sets after the write so a set beats a same-cycle clear
    hw_set = {s_nxt.upd || i_pwm_update_done,
              flag_mode && i_evt_ratio_inc,
              flag_mode && i_evt_ratio_dec,
              i_evt_cur_limit,
              i_evt_emergency,
              i_evt_zero_cross,
              i_evt_demag_end,
              i_evt_commutation};
    s_nxt.status = s_nxt.status | (hw_set & {8{cke}});
    // switched mode ratio commands act at commutation
    if (cke && i_evt_commutation && !flag_mode) begin
      if (s_r.status[motor_ctrl_pkg::BIT_RATIO_INC] && s_r.ratio != motor_ctrl_pkg::RATIO_MAX) begin
        s_nxt.ratio = s_r.ratio + 4'h1;
        s_nxt.shr   = 1'b1;
      end else if (s_r.status[motor_ctrl_pkg::BIT_RATIO_DEC] && s_r.ratio != motor_ctrl_pkg::RATIO_MIN) begin
        s_nxt.ratio = s_r.ratio - 4'h1;
        s_nxt.shl   = 1'b1;
      end
    end
    // motor output drive per channel
    for (int k = 0; k < NUM_OUT; k++) begin
      if (!motor_output_enable) begin
        s_nxt.mco_oe[k] = (s_r.option[2*k +: 2] != motor_ctrl_pkg::OPT_HIZ);
        s_nxt.mco[k]    = (s_r.option[2*k +: 2] == motor_ctrl_pkg::OPT_HIGH);
      end else begin
        s_nxt.mco_oe[k] = 1'b1;
        if (i_direct_access && !cke) begin
          s_nxt.mco[k] = i_phase_state_register[k];
        end else if (i_direct_access) begin
          s_nxt.mco[k] = i_pwm_applied[k] ? i_pwm_phase[k] : i_phase_state_register[k];
        end else if (!cke) begin
          if (i_pwm_applied[k]) begin
            s_nxt.mco[k] = !i_voltage_current_select;
          end else begin
            s_nxt.mco[k] = s_r.mco[k];
          end
        end else begin
          s_nxt.mco[k] = i_pwm_phase[k];
        end
      end
    end
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r.status <= motor_ctrl_pkg::RST_STATUS;
      s_r.ctrl   <= motor_ctrl_pkg::RST_CTRL_A;
      s_r.mask   <= motor_ctrl_pkg::RST_MASK;
      s_r.option <= {(NUM_OUT/6){motor_ctrl_pkg::RST_OPTION}};
      s_r.ratio  <= motor_ctrl_pkg::RST_RATIO;
      s_r.cke_d  <= 1'b0;
      s_r.upd    <= 1'b0;
      s_r.shr    <= 1'b0;
      s_r.shl    <= 1'b0;
      s_r.mco    <= '0;
      s_r.mco_oe <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // apb answer, zero wait states
  always_comb begin
    o_prdata = 32'h0000_0000;
    case (i_paddr)
      motor_ctrl_pkg::OFS_STATUS: o_prdata[7:0]           = s_r.status;
      motor_ctrl_pkg::OFS_CTRL_A: o_prdata[7:0]           = s_r.ctrl;
      motor_ctrl_pkg::OFS_MASK:   o_prdata[7:0]           = s_r.mask;
      motor_ctrl_pkg::OFS_OPTION: o_prdata[2*NUM_OUT-1:0] = s_r.option;
      motor_ctrl_pkg::OFS_RATIO:  o_prdata[3:0]           = s_r.ratio;
      default: o_prdata = 32'h0000_0000;
    endcase
  end
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_mapped(i_paddr);

  // peripheral control outputs
  assign o_periph_clk_run         = cke;
  assign o_pwm_counter_reset      = !cke;
  assign o_preload_transfer       = s_r.upd;
  assign o_timer_shift_right      = s_r.shr;
  assign o_timer_shift_left       = s_r.shl;
  assign o_step_ratio_prescaler   = s_r.ratio;
  assign o_position_sensor_select = s_r.ctrl[motor_ctrl_pkg::BIT_POS_SENSOR];
  assign o_demag_sampling_run     = cke;
  // zero sampling with outputs off in sensorless pwm-rate sampling follows the select bit
  assign o_zero_sampling_run = cke && (motor_output_enable || o_position_sensor_select || i_sampling_clock_select ||
                                       i_zero_sampling_select);
  // pwm polarity per commutation phase
  always_comb begin
    case (i_phase_segment)
      motor_ctrl_pkg::SEG_C_TO_D: o_pwm_on_low = i_output_mode_bits[2];
      motor_ctrl_pkg::SEG_D_TO_Z: o_pwm_on_low = o_position_sensor_select ? i_output_mode_bits[2]
                                                                            : i_output_mode_bits[1];
      motor_ctrl_pkg::SEG_Z_TO_C: o_pwm_on_low = i_output_mode_bits[0];
      default: o_pwm_on_low = i_output_mode_bits[0];
    endcase
  end
  assign o_motor_phase_outputs = s_r.mco;
  assign o_motor_phase_oe      = s_r.mco_oe;
  // level requests held while flag and mask are both set and global mask is clear
  assign o_irq_req = s_r.status & s_r.mask & {8{!i_global_int_mask}};

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  sequence switched_commut;
    cke && i_evt_commutation && !flag_mode;
  endsequence

  a_force_update: assert property (wr_en && i_paddr == motor_ctrl_pkg::OFS_STATUS &&
    wbyte == motor_ctrl_pkg::STATUS_FORCE_UPD && cke |=> o_preload_transfer && s_r.status[7])
    else $error("all-ones write did not force update");
  a_update_flag: assert property (cke && i_pwm_update_done |=> s_r.status[7])
    else $error("update flag not set");
  a_auto_no_set: assert property (i_autoswitch_select && !cke |=>
    (s_r.status & ~$past(s_r.status)) == 8'h00)
    else $error("software set a flag in autoswitched mode");
  a_ratio_up: assert property (switched_commut ##0 s_r.status[6] && s_r.ratio != 4'hf |=>
    o_timer_shift_right && s_r.ratio == $past(s_r.ratio) + 4'h1)
    else $error("ratio increment missing");
  a_ratio_down: assert property (switched_commut ##0 !s_r.status[6] && s_r.status[5] &&
    s_r.ratio != 4'h0 |=> o_timer_shift_left && s_r.ratio == $past(s_r.ratio) - 4'h1)
    else $error("ratio decrement missing");
  a_emerg_flag: assert property (cke && i_evt_emergency |=> s_r.status[3])
    else $error("emergency flag not set");
  a_stop_events: assert property (!cke |=> !o_preload_transfer)
    else $error("preload transfer while clocks stopped");
  a_clk_enable: assert property ($rose(cke) |=> o_preload_transfer)
    else $error("no transfer on clock enable");
  a_out_reset: assert property (!motor_output_enable && s_r.option[1:0] == motor_ctrl_pkg::OPT_HIZ |=>
    !o_motor_phase_oe[0])
    else $error("output 0 driven in reset state");
  a_irq_gate: assert property (o_irq_req[0] |-> s_r.status[0] && s_r.mask[0] &&
    !i_global_int_mask)
    else $error("request without flag and mask");

endmodule : motor_ctrl_regs

`default_nettype wire

// ===== tb/motor_bridge_model.sv
// inverter gate-drive inputs seen from the block's six phase output pins
// assumes oe high while the block drives a pin; gate inputs carry pull-downs
`timescale 1ns/1ps
`default_nettype none

module motor_bridge_model (
  // pins from the block
  input  wire logic [5:0] i_drive,
  input  wire logic [5:0] i_oe,
  // gate levels seen by the switches
  output logic      [5:0] o_gate_level
);
  // an undriven pin falls to the pull-down level
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      o_gate_level[i] = (i_oe[i] === 1'b1) ? i_drive[i] : 1'b0;
    end
  end
endmodule : motor_bridge_model

`default_nettype wire

// ===== tb/test_motor_ctrl_status_and_control_a.sv
// self-checking bench for the motor controller status and control-a registers
// assumes motor_ctrl_pkg, motor_ctrl_regs and motor_bridge_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module test_motor_ctrl_status_and_control_a;
  localparam logic [7:0] ST = motor_ctrl_pkg::OFS_STATUS;
  localparam logic [7:0] CA = motor_ctrl_pkg::OFS_CTRL_A;
  localparam logic [7:0] MK = motor_ctrl_pkg::OFS_MASK;
  logic        sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, evt = 8'h00, irq;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, clk_run, cnt_rst, preload, shr, shl;
  logic        autoswitch = 1'b0, volt_cur = 1'b0, direct = 1'b0, glob_mask = 1'b0;
  logic [1:0]  sensor_type = 2'h0;
  logic [2:0]  os_bits = 3'h0;
  logic [1:0]  seg = 2'h0;
  logic        zero_sampling_select = 1'b0, on_low, zrun, sens_sel;
  logic [3:0]  ratio;
  logic [5:0]  pwm_phase = 6'h00, applied = 6'h00, phase_state = 6'h00, phase_out, phase_oe, pin;
  int          mismatches = 0, check_count = 0, pre_cnt = 0, shr_cnt = 0, shl_cnt = 0, p0;

  // clock
  always #10 sys_clk = ~sys_clk;

  motor_ctrl_regs uut (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_pwm_update_done(evt[7]), .i_evt_ratio_inc(evt[6]), .i_evt_ratio_dec(evt[5]),
    .i_evt_cur_limit(evt[4]), .i_evt_emergency(evt[3]), .i_evt_zero_cross(evt[2]),
    .i_evt_demag_end(evt[1]), .i_evt_commutation(evt[0]), .i_sensor_type_select(sensor_type),
    .i_autoswitch_select(autoswitch), .i_voltage_current_select(volt_cur), .i_direct_access(direct),
    .i_sampling_clock_select(1'b0), .i_zero_sampling_select(zero_sampling_select), .i_output_mode_bits(os_bits),
    .i_phase_segment(seg), .i_global_int_mask(glob_mask), .i_pwm_phase(pwm_phase),
    .i_pwm_applied(applied), .i_phase_state_register(phase_state), .o_periph_clk_run(clk_run),
    .o_pwm_counter_reset(cnt_rst), .o_preload_transfer(preload), .o_timer_shift_right(shr),
    .o_timer_shift_left(shl), .o_step_ratio_prescaler(ratio), .o_zero_sampling_run(zrun),
    .o_demag_sampling_run(), .o_pwm_on_low(on_low), .o_position_sensor_select(sens_sel),
    .o_motor_phase_outputs(phase_out), .o_motor_phase_oe(phase_oe), .o_irq_req(irq));

  motor_bridge_model bridge (.i_drive(phase_out), .i_oe(phase_oe), .o_gate_level(pin));

  // count the one-cycle control pulses
  always @(posedge sys_clk) begin
    if (preload === 1'b1) pre_cnt <= pre_cnt + 1;
    if (shr === 1'b1) shr_cnt <= shr_cnt + 1;
    if (shl === 1'b1) shl_cnt <= shl_cnt + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      mismatches++;
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, addr, data};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 16) chk(0, 1, "apb timeout");
  endtask : apb

  task automatic rdc(input logic [7:0] addr, input logic [31:0] exp, input string msg);
    apb(1'b0, addr, 32'h0);
    chk(rd, exp, msg);
  endtask : rdc

  task automatic pulse(input int idx);
    @(posedge sys_clk);
    evt[idx] <= 1'b1;
    @(posedge sys_clk);
    evt[idx] <= 1'b0;
  endtask : pulse

  task automatic mode(input logic sw, input logic [1:0] st, input logic vc, input logic da);
    @(posedge sys_clk);
    {autoswitch, sensor_type, volt_cur, direct} <= {sw, st, vc, da};
  endtask : mode

  task automatic t_reset();
    rdc(ST, 32'h0, "status reset");
    rdc(CA, 32'h0, "control reset");
    chk(cnt_rst, 1'b1, "counter held");
    apb(1'b1, 8'h20, 32'hff);
    chk(err, 1'b1, "unmapped error");
    rdc(8'h20, 32'h0, "unmapped read");
  endtask : t_reset

  // each hardware event sets its own flag; complement store clears it
  task automatic t_flags();
    mode(1'b1, 2'h0, 1'b0, 1'b0);
    p0 = pre_cnt;
    apb(1'b1, CA, 32'h40);
    repeat (3) @(posedge sys_clk);
    chk(pre_cnt - p0, 1, "preload on enable");
    chk({clk_run, cnt_rst}, 2'b10, "clocks run");
    rdc(ST, 32'h80, "update flag on enable");
    apb(1'b1, ST, 32'h7f);
    for (int i = 0; i < 8; i++) begin
      pulse(i);
      rdc(ST, 32'h1 << i, "event flag");
      apb(1'b1, ST, 32'(8'(~(8'h01 << i))));
      rdc(ST, 32'h0, "ones keep, zero clears");
    end
    for (int k = 1; k < 4; k++) begin
      mode(1'b0, 2'(k), 1'b0, 1'b0);
      pulse(6);
      rdc(ST, 32'h40, "speed sensor pending");
      apb(1'b1, ST, 32'hbf);
    end
  endtask : t_flags

  task automatic t_irq();
    apb(1'b1, MK, 32'h01);
    pulse(0);
    repeat (3) @(posedge sys_clk);
    chk(irq, 8'h01, "irq held");
    glob_mask <= 1'b1;
    @(posedge sys_clk);
    chk(irq, 8'h00, "global mask");
    glob_mask <= 1'b0;
    apb(1'b1, ST, 32'hfe);
    @(posedge sys_clk);
    chk(irq, 8'h00, "flag cleared");
  endtask : t_irq

  // forced update, then everything with peripheral clocks stopped
  task automatic t_update();
    mode(1'b1, 2'h0, 1'b0, 1'b0);
    p0 = pre_cnt;
    apb(1'b1, ST, 32'hff);
    repeat (2) @(posedge sys_clk);
    chk(pre_cnt - p0, 1, "forced transfer");
    rdc(ST, 32'h80, "update flag");
    apb(1'b1, ST, 32'h7f);
    apb(1'b1, CA, 32'h20);
    @(posedge sys_clk);
    chk(cnt_rst, 1'b1, "counter held off");
    pulse(2);
    p0 = pre_cnt;
    apb(1'b1, ST, 32'hff);
    repeat (2) @(posedge sys_clk);
    chk(pre_cnt - p0, 0, "no transfer off");
    rdc(ST, 32'h0, "no events off");
    apb(1'b1, MK, 32'h5a);
    rdc(MK, 32'h5a, "write while off");
    rdc(CA, 32'h20, "sensor select");
  endtask : t_update

  // recommended command sequence, then step up, down and saturate at zero
  task automatic t_ratio();
    mode(1'b0, 2'h0, 1'b0, 1'b0);
    apb(1'b1, CA, 32'h40);
    apb(1'b1, ST, 32'h7f);
    apb(1'b1, ST, 32'h9f);
    apb(1'b1, ST, 32'hbf);
    apb(1'b1, ST, 32'hdf);
    rdc(ST, 32'h40, "increment command");
    p0 = shr_cnt;
    pulse(0);
    repeat (2) @(posedge sys_clk);
    chk({ratio, 28'(shr_cnt - p0)}, {4'h1, 28'h1}, "ratio up, shift right");
    p0 = shl_cnt;
    apb(1'b1, ST, 32'hbf);
    pulse(0);
    repeat (2) @(posedge sys_clk);
    chk({ratio, 28'(shl_cnt - p0)}, {4'h0, 28'h1}, "ratio down, shift left");
    pulse(0);
    repeat (2) @(posedge sys_clk);
    chk({ratio, 28'(shl_cnt - p0)}, {4'h0, 28'h1}, "ratio floor");
    apb(1'b1, ST, 32'h00);
  endtask : t_ratio

  task automatic t_outputs();
    apb(1'b1, motor_ctrl_pkg::OFS_OPTION, 32'h924);
    repeat (2) @(posedge sys_clk);
    chk({phase_oe, pin}, {6'h36, 6'h12}, "reset state");
    pwm_phase <= 6'h2b;
    apb(1'b1, CA, 32'hc0);
    repeat (2) @(posedge sys_clk);
    chk({phase_oe, pin}, {6'h3f, 6'h2b}, "running");
    applied <= 6'h0f;
    apb(1'b1, CA, 32'h80);
    repeat (2) @(posedge sys_clk);
    chk(pin, 6'h2f, "frozen voltage");
    mode(1'b0, 2'h0, 1'b1, 1'b0);
    repeat (2) @(posedge sys_clk);
    chk(pin, 6'h20, "frozen current");
    phase_state <= 6'h15;
    mode(1'b0, 2'h0, 1'b1, 1'b1);
    repeat (2) @(posedge sys_clk);
    chk(pin, 6'h15, "static direct");
    apb(1'b1, CA, 32'hc0);
    repeat (2) @(posedge sys_clk);
    chk(pin, 6'h1b, "pwm direct");
    apb(1'b1, CA, 32'h40);
    apb(1'b1, CA, 32'h00);
  endtask : t_outputs

  // pwm polarity in segment SEG_D_TO_Z and zero sampling with outputs off
  task automatic t_modes();
    apb(1'b1, CA, 32'h40);
    {os_bits, seg, zero_sampling_select} <= {3'b010, 2'h1, 1'b0};
    @(posedge sys_clk);
    chk({on_low, zrun, sens_sel}, 3'b100, "sensorless segment, zero sampling off");
    zero_sampling_select <= 1'b1;
    @(posedge sys_clk);
    chk(zrun, 1'b1, "zero sampling on");
    apb(1'b1, CA, 32'h60);
    @(posedge sys_clk);
    chk({on_low, zrun, sens_sel}, 3'b011, "sensor mode ignores middle bit");
  endtask : t_modes

  task automatic tally_and_finish();
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_flags();
    t_irq();
    t_update();
    t_ratio();
    t_outputs();
    t_modes();
    tally_and_finish();
  end

  // watchdog
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end
endmodule : test_motor_ctrl_status_and_control_a

`default_nettype wire
